//--- verif/mdq_core_monitor.sv
module mdq_core_monitor (
    input wire logic                  clock_i,
    input wire logic                  arst_n_i,
    input wire mdq_pkg::mdq_reg_req_t reg_i,
    input wire logic [15:0]           reg_rdata_o,
    input wire mdq_pkg::mdq_mem_t     mem_o,
    input wire logic [15:0]           mem_rdata_i,
    input wire logic [5:0]            irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import mdq_pkg::*;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    chk_read_then_write: assert property (mem_o.req && !mem_o.we |-> ##2 mem_o.req && mem_o.we)
        else $error("write does not follow read");
    chk_write_had_read: assert property (mem_o.req && mem_o.we |-> $past(mem_o.req && !mem_o.we, 2))
        else $error("write without read");
    chk_read_spacing: assert property (mem_o.req && !mem_o.we |=> !(mem_o.req && !mem_o.we) [*2])
        else $error("reads too close");
    chk_space_legal: assert property (mem_o.req |-> mem_o.space != 2'b11)
        else $error("reserved space used");
    chk_irq_single: assert property (|irq_o |=> (irq_o & $past(irq_o)) == 6'h00)
        else $error("interrupt longer than a pulse");
    chk_irq_with_req: assert property (|irq_o |-> mem_o.req)
        else $error("interrupt outside a transfer");
    chk_rdata_idle: assert property (!$past(reg_i.re) |-> reg_rdata_o == 16'h0000)
        else $error("read data outside read cycle");
    chk_disable_stops: assert property (reg_i.we && reg_i.addr == 8'h00 && reg_i.wdata[5:0] == 6'h00
        |-> ##9 (!mem_o.req) [*8])
        else $error("transfers after disable");
endmodule : mdq_core_monitor

bind mdq_core mdq_core_monitor mdq_core_monitor_i (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .reg_i(reg_i), .reg_rdata_o(reg_rdata_o), .mem_o(mem_o), .mem_rdata_i(mem_rdata_i),
    .irq_o(irq_o));

//--- verif/mdq_mem_model.sv
module mdq_mem_model (
    input  wire logic              clock_i,
    input  wire logic              arst_n_i,
    input  wire mdq_pkg::mdq_mem_t mem_i,
    output logic [15:0]            rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 16'h0000;
        end else begin
            // valid for one cycle only; otherwise toggles so stale data cannot pass
            rdata_o <= (mem_i.req && !mem_i.we) ? mem_i.addr ^ 16'ha5c3 : ~rdata_o;
        end
    end
endmodule : mdq_mem_model

//--- verif/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clock_i;
    logic                  arst_n_i;
    mdq_pkg::mdq_reg_req_t reg_i;
    mdq_pkg::mdq_mem_t     mem_o;
    logic [15:0]           reg_rdata_o;
    logic [15:0]           mem_rdata_i;
    logic [5:0]            irq_o;
    logic [15:0]           es0, fs0, es1, fs1;
    logic [31:0]           q[$];
    int bad_count, n_compared, irqs, i0;
    bit free_run;
    int s[6], d[6], e[6], f[6], nn[6], ff[6], sm[6], dm[6], dw[6];
    mdq_core mdq_core_i (.clock_i(clock_i), .arst_n_i(arst_n_i), .reg_i(reg_i),
        .reg_rdata_o(reg_rdata_o), .mem_o(mem_o), .mem_rdata_i(mem_rdata_i), .irq_o(irq_o));
    mdq_mem_model mdq_mem_model_i (.clock_i(clock_i), .arst_n_i(arst_n_i), .mem_i(mem_o),
        .rdata_o(mem_rdata_i));
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    task automatic give_verdict();
        $display("compared %0d wrong %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic wr(logic [7:0] a, logic [15:0] v);
        reg_i <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
        @(posedge clock_i);
        reg_i <= '0;
        @(posedge clock_i);
    endtask : wr
    task automatic rd(logic [7:0] a, output logic [15:0] v);
        reg_i <= '{addr: a, wdata: 16'h0000, we: 1'b0, re: 1'b1};
        @(posedge clock_i);
        reg_i <= '0;
        @(negedge clock_i);
        v = reg_rdata_o;
        @(posedge clock_i);
    endtask : rd
    function automatic int stp(int sel, bit lst);
        case (sel)
            1: return 1;
            2: return -1;
            3: return lst ? int'($signed(fs0)) : int'($signed(es0));
            4: return lst ? int'($signed(fs1)) : int'($signed(es1));
            default: return 0;
        endcase
    endfunction : stp
    function automatic bit elem(int c);
        bit lst;
        for (int h = 0; h <= dw[c]; h++) begin
            lst = (e[c] == nn[c]) && (h == dw[c]);
            q.push_back({16'(d[c]), 16'(s[c]) ^ 16'ha5c3});
            s[c] += stp(sm[c], lst);
            d[c] += stp(dm[c], lst);
        end
        if (e[c] < nn[c]) begin
            e[c]++;
            return 1'b0;
        end
        e[c] = 0;
        if (f[c] < ff[c]) begin
            f[c]++;
            return 1'b0;
        end
        f[c] = 0;
        return 1'b1;
    endfunction : elem
    task automatic blk(int c);
        while (!elem(c)) ;
    endtask : blk
    task automatic cfg(int c, int sa, int da, int ec, int fc, logic [15:0] md);
        logic [7:0] b;
        b = 8'((c + 1) * 16);
        wr(b, 16'(sa));
        wr(b + 8'h01, 16'(da));
        wr(b + 8'h02, 16'(ec));
        wr(b + 8'h03, 16'(fc));
        wr(b + 8'h04, md);
        s[c] = sa;
        d[c] = da;
        nn[c] = ec;
        ff[c] = fc;
        e[c] = 0;
        f[c] = 0;
        sm[c] = md[10:8];
        dm[c] = md[4:2];
        dw[c] = md[5];
    endtask : cfg
    task automatic wait_done(int c, int xi);
        logic [15:0] v;
        int n;
        n = 0;
        v = 16'hffff;
        while (v[c] !== 1'b0 && n < 300) begin
            rd(8'h00, v);
            n++;
        end
        repeat (4) @(posedge clock_i);
        chk("enable", 0, 32'(v[c]));
        chk("writes left", 0, q.size());
        chk("irq count", xi, irqs - i0);
        $display("test on channel %0d done", c);
    endtask : wait_done
    always @(negedge clock_i) begin
        if (mem_o.req === 1'b1 && mem_o.we === 1'b1) begin
            if (q.size() > 0) chk("mem write", q.pop_front(), {mem_o.addr, mem_o.wdata});
            else if (!free_run) chk("spare write", 0, {mem_o.addr, mem_o.wdata});
        end
    end
    always @(posedge clock_i) irqs <= irqs + $countones(irq_o);
    initial begin
        repeat (20000) @(posedge clock_i);
        bad_count++;
        give_verdict();
    end
    initial begin
        logic [15:0] v;
        int n;
        arst_n_i = 1'b0;
        reg_i = '0;
        irqs = 0;
        void'($urandom(85));
        es0 = 16'($urandom_range(1, 8));
        fs0 = 16'h0000 - 16'($urandom_range(1, 8));
        es1 = 16'($urandom_range(2, 5));
        fs1 = 16'($urandom_range(16, 32));
        repeat (6) @(posedge clock_i);
        arst_n_i <= 1'b1;
        @(posedge clock_i);
        rd(8'h00, v);
        chk("priority reset", 0, v);
        rd(8'h13, v);
        chk("frame count reset", 0, v);
        rd(8'hf0, v);
        chk("unmapped", 0, v);
        wr(8'h01, es0);
        wr(8'h02, es1);
        wr(8'h03, fs0);
        wr(8'h04, fs1);
        rd(8'h03, v);
        chk("frame step", fs0, v);
        $display("test registers done");
        // three elements, two frames, interrupt at block end only
        cfg(0, 'h0100, 'h0800, 2, 1, 16'h414d);
        blk(0);
        i0 = irqs;
        wr(8'h00, 16'h0001);
        wait_done(0, 1);
        // doubleword, decrementing source, interrupts disabled
        cfg(1, 'h1100, 'h1800, 1, 0, 16'h2271);
        blk(1);
        i0 = irqs;
        wr(8'h00, 16'h0002);
        wait_done(1, 0);
        // two frames with per-frame timing: one at frame end, one at block end
        cfg(2, 'h2100, 'h2800, 1, 1, 16'h614d);
        blk(2);
        i0 = irqs;
        wr(8'h00, 16'h0004);
        wait_done(2, 2);
        for (int r = 0; r < 2; r++) begin
            cfg(3, 'h3100, 'h3800, 7, 0, 16'h8145);
            blk(3);
            s[3] = 'h2000 + (r ? 'h300 : 0) + r;
            d[3] = 'h2800 + (r ? 'h300 : 0) + r;
            nn[3] = 2;
            ff[3] = 1;
            blk(3);
            wr(8'h00, 16'(r << 15) | 16'h0008);
            for (int j = 0; j < 6; j += 3) begin
                wr(8'((j + 1) * 16 + 5), 16'('h2000 + j * 'h100 + r));
                wr(8'((j + 1) * 16 + 6), 16'('h2800 + j * 'h100 + r));
                wr(8'((j + 1) * 16 + 7), 16'h0002);
                wr(8'((j + 1) * 16 + 8), 16'h0001);
            end
            n = 0;
            while (q.size() > 0 && n < 400) begin
                @(posedge clock_i);
                n++;
            end
            chk("reload writes left", 0, q.size());
            free_run = 1'b1;
            wr(8'h00, 16'(r << 15));
            repeat (12) @(posedge clock_i);
            free_run = 1'b0;
            $display("test reload set %0d done", r);
        end
        // one high channel against two low ones
        for (int c = 1; c < 6; c += 3) cfg(c, c * 'h1000 + 'h100, c * 'h1000 + 'h800, 1, 0, 16'h0145);
        cfg(5, 'h5100, 'h5800, 1, 0, 16'h0145);
        i0 = irqs;
        void'(elem(1));
        void'(elem(1));
        for (int k = 0; k < 4; k++) void'(elem(4 + k % 2));
        wr(8'h00, 16'h0232);
        wait_done(5, 0);
        give_verdict();
    end
endmodule : tb

//--- verilog/mdq_cfg.svh
`ifndef MDQ_CFG_SVH
`define MDQ_CFG_SVH

`define MDQ_NCH        6
`define MDQ_GLB_PAGE   4'h0
`define MDQ_CH_PAGE0   4'h1
`define MDQ_OFS_PRIO   4'h0
`define MDQ_OFS_ES0    4'h1
`define MDQ_OFS_ES1    4'h2
`define MDQ_OFS_FS0    4'h3
`define MDQ_OFS_FS1    4'h4
`define MDQ_OFS_SRC    4'h0
`define MDQ_OFS_DST    4'h1
`define MDQ_OFS_EC     4'h2
`define MDQ_OFS_FC     4'h3
`define MDQ_OFS_MODE   4'h4
`define MDQ_OFS_RSRC   4'h5
`define MDQ_OFS_RDST   4'h6
`define MDQ_OFS_REC    4'h7
`define MDQ_OFS_RFC    4'h8
`define MDQ_EN_POS     0
`define MDQ_HI_POS     8
`define MDQ_RSEL_POS   15
`define MDQ_AUTO_POS   15
`define MDQ_IEN_POS    14
`define MDQ_ITIM_POS   13
`define MDQ_ABU_POS    12
`define MDQ_SOURCE_INDEX_SELECT_POS   8
`define MDQ_SSP_POS    6
`define MDQ_DW_POS     5
`define MDQ_DESTINATION_INDEX_SELECT_POS   2
`define MDQ_DSP_POS    0
`define MDQ_IDX_NONE   3'h0
`define MDQ_IDX_INC    3'h1
`define MDQ_IDX_DEC    3'h2
`define MDQ_IDX_PAIR0  3'h3
`define MDQ_IDX_PAIR1  3'h4
`define MDQ_RST_W16    16'h0000
`define MDQ_RST_W8     8'h00
`define MDQ_RST_EN     6'h00

`endif

//--- verilog/mdq_core.sv
// What this block does
// - dma space decode ignores cpu map bits
// - each channel has own high/low priority
// - equal-priority requesters served round robin
// - source/destination post inc, dec or indexed
// - auto_reinit_enable reloads working values at block end
// - new reload values apply at next block
// - select clear: all use channel zero set
// - select set: each uses own set
// - 8-bit frame count, zero means one frame
// - frame count decrements at last read
// - frame counter reloaded only with auto_reinit_enable or autobuffer
// - 16-bit element count, ffff gives 65536
// - auto_reinit_enable reloads element count at block end
// - doubleword: two halves, one element counted
// - per-channel select picks index register pair
// - element index applied except last transfer
// - frame index applied on last frame transfer
// - interrupt enable clear blocks all interrupts
// - autobuffer: full, or half and full
// - multiframe: block end, or every frame end
// - two element and two frame index registers
// - finished channel clears its enable bit unless auto_reinit_enable or autobuffer is set
`include "mdq_cfg.svh"

module mdq_core (
    input  wire logic             clock_i,
    input  wire logic             arst_n_i,
    input  wire mdq_pkg::mdq_reg_req_t reg_i,
    output logic [15:0]           reg_rdata_o,
    output mdq_pkg::mdq_mem_t     mem_o,
    input  wire logic [15:0]      mem_rdata_i,
    output logic [5:0]            irq_o
);
    import mdq_pkg::*;

    mdq_all_t s_q;
    mdq_all_t s_d;

    // rotating search starting just after the last grant
    function automatic logic [3:0] pick(input logic [5:0] mask,
                                        input logic [2:0] last);
        logic [3:0] res;
        logic [2:0] idx;
        res = 4'h0;
        idx = last;
        for (int k = 0; k < `MDQ_NCH; k++) begin
            idx = (idx == 3'h5) ? 3'h0 : idx + 3'h1;
            if (mask[idx] && !res[3]) begin
                res = {1'b1, idx};
            end
        end
        return res;
    endfunction : pick

    // two's-complement add wraps, so a negative step walks downward
    function automatic logic [15:0] step(input logic [2:0]  sel,
                                         input logic        lastx,
                                         input logic [15:0] e0,
                                         input logic [15:0] e1,
                                         input logic [15:0] f0,
                                         input logic [15:0] f1);
        logic [15:0] v;
        v = 16'h0000;
        case (sel)
            `MDQ_IDX_INC:   v = 16'h0001;
            `MDQ_IDX_DEC:   v = 16'hffff;
            `MDQ_IDX_PAIR0: v = lastx ? f0 : e0;
            `MDQ_IDX_PAIR1: v = lastx ? f1 : e1;
            default:        v = 16'h0000;
        endcase
        return v;
    endfunction : step

    logic [3:0]  pk_hi;
    logic [3:0]  pk_lo;
    mdq_chan_t   cc;
    mdq_chan_t   rl;
    logic        dw;
    logic        cnt;
    logic        lastx;
    logic        ien;
    logic        itim;
    logic        autobuffering_mode;
    logic [15:0] dec_ec;

    always_comb begin
        s_d = s_q;
        s_d.irq = 6'h00;
        s_d.mem.req = 1'b0;
        s_d.mem.we = 1'b0;
        s_d.rdata = 16'h0000;
        cc = s_q.ch[s_q.cur];
        rl = s_q.rsel ? s_q.ch[s_q.cur] : s_q.ch[0];
        dw = cc.mode[`MDQ_DW_POS];
        ien = cc.mode[`MDQ_IEN_POS];
        itim = cc.mode[`MDQ_ITIM_POS];
        autobuffering_mode = cc.mode[`MDQ_ABU_POS];
        cnt = !dw || s_q.half;
        lastx = (cc.ec == 16'h0000) && cnt;
        dec_ec = cc.ec - 16'h0001;
        pk_hi = pick(s_q.en & s_q.hi, s_q.last_hi);
        pk_lo = pick(s_q.en & ~s_q.hi, s_q.last_lo);

        // register writes land first so the engine below can override
        if (reg_i.we) begin
            if (reg_i.addr[7:4] == `MDQ_GLB_PAGE) begin
                case (reg_i.addr[3:0])
                    `MDQ_OFS_PRIO: begin
                        s_d.en = reg_i.wdata[`MDQ_EN_POS +: 6];
                        s_d.hi = reg_i.wdata[`MDQ_HI_POS +: 6];
                        s_d.rsel = reg_i.wdata[`MDQ_RSEL_POS];
                    end
                    `MDQ_OFS_ES0: s_d.es0 = reg_i.wdata;
                    `MDQ_OFS_ES1: s_d.es1 = reg_i.wdata;
                    `MDQ_OFS_FS0: s_d.fs0 = reg_i.wdata;
                    `MDQ_OFS_FS1: s_d.fs1 = reg_i.wdata;
                    default: ;
                endcase
            end
            for (int i = 0; i < `MDQ_NCH; i++) begin
                if (reg_i.addr[7:4] == 4'(i + 1)) begin
                    case (reg_i.addr[3:0])
                        `MDQ_OFS_SRC: s_d.ch[i].src = reg_i.wdata;
                        `MDQ_OFS_DST: s_d.ch[i].dst = reg_i.wdata;
                        `MDQ_OFS_EC: begin
                            s_d.ch[i].ec = reg_i.wdata;
                            s_d.ch[i].elen = reg_i.wdata;
                        end
                        `MDQ_OFS_FC: s_d.ch[i].fc = reg_i.wdata[7:0];
                        `MDQ_OFS_MODE: s_d.ch[i].mode = reg_i.wdata;
                        // reload set is only copied at a block boundary
                        `MDQ_OFS_RSRC: s_d.ch[i].rsrc = reg_i.wdata;
                        `MDQ_OFS_RDST: s_d.ch[i].rdst = reg_i.wdata;
                        `MDQ_OFS_REC: s_d.ch[i].rec = reg_i.wdata;
                        `MDQ_OFS_RFC: s_d.ch[i].rfc = reg_i.wdata[7:0];
                        default: ;
                    endcase
                end
            end
        end

        if (reg_i.re) begin
            if (reg_i.addr[7:4] == `MDQ_GLB_PAGE) begin
                case (reg_i.addr[3:0])
                    `MDQ_OFS_PRIO: s_d.rdata = {s_q.rsel, 1'b0, s_q.hi,
                                                2'b00, s_q.en};
                    `MDQ_OFS_ES0: s_d.rdata = s_q.es0;
                    `MDQ_OFS_ES1: s_d.rdata = s_q.es1;
                    `MDQ_OFS_FS0: s_d.rdata = s_q.fs0;
                    `MDQ_OFS_FS1: s_d.rdata = s_q.fs1;
                    default: s_d.rdata = 16'h0000;
                endcase
            end
            for (int i = 0; i < `MDQ_NCH; i++) begin
                if (reg_i.addr[7:4] == 4'(i + 1)) begin
                    case (reg_i.addr[3:0])
                        `MDQ_OFS_SRC: s_d.rdata = s_q.ch[i].src;
                        `MDQ_OFS_DST: s_d.rdata = s_q.ch[i].dst;
                        `MDQ_OFS_EC: s_d.rdata = s_q.ch[i].ec;
                        `MDQ_OFS_FC: s_d.rdata = {8'h00, s_q.ch[i].fc};
                        `MDQ_OFS_MODE: s_d.rdata = s_q.ch[i].mode;
                        `MDQ_OFS_RSRC: s_d.rdata = s_q.ch[i].rsrc;
                        `MDQ_OFS_RDST: s_d.rdata = s_q.ch[i].rdst;
                        `MDQ_OFS_REC: s_d.rdata = s_q.ch[i].rec;
                        `MDQ_OFS_RFC: s_d.rdata = {8'h00, s_q.ch[i].rfc};
                        default: s_d.rdata = 16'h0000;
                    endcase
                end
            end
        end

        case (s_q.st)
            ST_ARB: begin
                s_d.half = 1'b0;
                if (pk_hi[3]) begin
                    s_d.cur = pk_hi[2:0];
                    s_d.last_hi = pk_hi[2:0];
                    s_d.st = ST_RD;
                end else if (pk_lo[3]) begin
                    s_d.cur = pk_lo[2:0];
                    s_d.last_lo = pk_lo[2:0];
                    s_d.st = ST_RD;
                end
            end
            ST_RD: begin
                // space code goes straight out, no cpu map bits involved
                s_d.mem.req = 1'b1;
                s_d.mem.space = cc.mode[`MDQ_SSP_POS +: 2];
                s_d.mem.addr = cc.src;
                s_d.mem.wdata = 16'h0000;
                s_d.ch[s_q.cur].src = cc.src + step(cc.mode[`MDQ_SOURCE_INDEX_SELECT_POS +: 3],
                    lastx, s_q.es0, s_q.es1, s_q.fs0, s_q.fs1);
                s_d.lastf = lastx;
                s_d.blk = 1'b0;
                if (cnt) begin
                    if (!lastx) begin
                        s_d.ch[s_q.cur].ec = dec_ec;
                        if (autobuffering_mode && itim && ien && dec_ec == {1'b0, cc.elen[15:1]}) begin
                            s_d.irq[s_q.cur] = 1'b1;
                        end
                    end else if (cc.fc != 8'h00) begin
                        s_d.ch[s_q.cur].fc = cc.fc - 8'h01;
                        s_d.ch[s_q.cur].ec = cc.elen;
                        if (ien && itim && !autobuffering_mode) begin
                            s_d.irq[s_q.cur] = 1'b1;
                        end
                    end else begin
                        s_d.blk = 1'b1;
                    end
                end
                s_d.st = ST_WAIT;
            end
            ST_WAIT: begin
                s_d.st = ST_WR;
            end
            ST_WR: begin
                s_d.mem.req = 1'b1;
                s_d.mem.we = 1'b1;
                s_d.mem.space = cc.mode[`MDQ_DSP_POS +: 2];
                s_d.mem.addr = cc.dst;
                s_d.mem.wdata = mem_rdata_i;
                s_d.ch[s_q.cur].dst = cc.dst + step(cc.mode[`MDQ_DESTINATION_INDEX_SELECT_POS +: 3],
                    s_q.lastf, s_q.es0, s_q.es1, s_q.fs0, s_q.fs1);
                if (dw && !s_q.half) begin
                    s_d.half = 1'b1;
                    s_d.st = ST_RD;
                end else begin
                    s_d.st = ST_ARB;
                end
                if (s_q.blk) begin
                    s_d.irq[s_q.cur] = ien;
                    if (cc.mode[`MDQ_AUTO_POS] || autobuffering_mode) begin
                        s_d.ch[s_q.cur].src = rl.rsrc;
                        s_d.ch[s_q.cur].dst = rl.rdst;
                        s_d.ch[s_q.cur].ec = rl.rec;
                        s_d.ch[s_q.cur].elen = rl.rec;
                        s_d.ch[s_q.cur].fc = rl.rfc;
                    end else begin
                        // hardware clear beats a same-cycle software write
                        s_d.en[s_q.cur] = 1'b0;
                    end
                end
            end
            default: s_d.st = ST_ARB;
        endcase
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q <= '0;
            s_q.st <= ST_ARB;
            s_q.en <= `MDQ_RST_EN;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata_o = s_q.rdata;
    assign mem_o = s_q.mem;
    assign irq_o = s_q.irq;

endmodule : mdq_core

//--- verilog/mdq_pkg.sv
package mdq_pkg;

    typedef struct packed {
        logic [15:0] src;
        logic [15:0] dst;
        logic [15:0] ec;
        logic [15:0] elen;
        logic [15:0] mode;
        logic [15:0] rsrc;
        logic [15:0] rdst;
        logic [15:0] rec;
        logic [7:0]  fc;
        logic [7:0]  rfc;
    } mdq_chan_t;

    typedef enum logic [1:0] {
        ST_ARB  = 2'b00,
        ST_RD   = 2'b01,
        ST_WAIT = 2'b10,
        ST_WR   = 2'b11
    } mdq_state_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [1:0]  space;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mdq_mem_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        we;
        logic        re;
    } mdq_reg_req_t;

    typedef struct packed {
        mdq_chan_t [5:0] ch;
        logic [5:0]      en;
        logic [5:0]      hi;
        logic            rsel;
        logic [15:0]     es0;
        logic [15:0]     es1;
        logic [15:0]     fs0;
        logic [15:0]     fs1;
        mdq_state_t      st;
        logic [2:0]      cur;
        logic [2:0]      last_hi;
        logic [2:0]      last_lo;
        logic            half;
        logic            lastf;
        logic            blk;
        mdq_mem_t        mem;
        logic [15:0]     rdata;
        logic [5:0]      irq;
    } mdq_all_t;

endpackage : mdq_pkg
